// ===== sync_serial_pkg.sv
// shared constants for the synchronous serial master channel
package sync_serial_pkg;
	// register byte offsets
	localparam logic [7:0] off_data = 8'h00;
	localparam logic [7:0] off_ctrl = 8'h04;
	localparam logic [7:0] off_status = 8'h08;
	localparam logic [7:0] off_irq_status = 8'h0c;
	localparam logic [7:0] off_irq_mask = 8'h10;
	localparam logic [7:0] off_clk_enable = 8'h14;
	localparam logic [7:0] off_divider = 8'h18;
	// control field positions
	localparam int ctrl_rx_en_bit = 0;
	localparam int ctrl_tx_en_bit = 1;
	localparam int ctrl_src_bit = 2;
	localparam int ctrl_mode_lo = 3;
	localparam int ctrl_dir_bit = 5;
	// serial unit gate bit of the peripheral clock enable register
	localparam int clk_gate_bit = 2;
	// operation mode codes
	localparam logic [1:0] mode_csi = 2'h0;
	localparam logic [1:0] mode_async = 2'h1;
	localparam logic [1:0] mode_bad = 2'h3;
	// reset values and the zero byte
	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [7:0] pce_reset = 8'h00;
	localparam logic [7:0] div_reset = 8'h09;
	localparam logic [7:0] byte_zero = 8'h00;
	// interrupt status bits and character length
	localparam int irq_event_bit = 0;
	localparam int irq_mode_err_bit = 1;
	localparam int char_bits = 8;
endpackage

// ===== sync_serial_tick.sv
// divider producing a one-cycle enable at half the serial clock period
module sync_serial_tick
	import sync_serial_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic [7:0] half_period,
	// output enable
	output logic tick
);
	typedef struct packed {
		logic [7:0] count;
		logic tick;
	} tick_state_t;
	tick_state_t state, next_state;

	// count down and pulse on reaching zero; idle keeps the counter loaded
	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (!run) begin
			next_state.count = half_period;
		end else if (state.count == byte_zero) begin
			next_state.count = half_period;
			next_state.tick = 1'b1;
		end else begin
			next_state.count = state.count - 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick = state.tick;
endmodule // sync_serial_tick

// ===== sync_serial_shifter.sv
// eight-bit shift engine: drives the serial clock and data, samples input
module sync_serial_shifter
	import sync_serial_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic tick,
	input wire logic start,
	input wire logic [7:0] tx_byte,
	input wire logic lsb_first,
	input wire logic miso_sync,
	// status
	output logic busy,
	output logic done,
	output logic [7:0] rx_byte,
	output logic sck,
	output logic mosi
);
	typedef struct packed {
		logic busy;
		logic done;
		logic phase;
		logic [3:0] bits;
		logic [7:0] tx;
		logic [7:0] rx;
		logic sck;
	} shift_state_t;
	shift_state_t state, next_state;

	// idle high clock; data changes on falling edge, sampled on rising edge
	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		if (!state.busy) begin
			next_state.sck = 1'b1;
			// idle data line returns high one cycle after the last rise
			next_state.tx = 8'hff;
			if (start) begin
				next_state.busy = 1'b1;
				next_state.tx = tx_byte;
				next_state.bits = 4'h0;
				next_state.phase = 1'b0;
			end
		end else if (tick) begin
			if (!state.phase) begin
				next_state.sck = 1'b0;
				next_state.phase = 1'b1;
				// shifting on the fall keeps data away from the slave's sampling rise
				if (state.bits != 4'h0) begin
					next_state.tx = lsb_first ? {1'b1, state.tx[7:1]} : {state.tx[6:0], 1'b1};
				end
			end else begin
				next_state.sck = 1'b1;
				next_state.phase = 1'b0;
				next_state.rx = lsb_first ? {miso_sync, state.rx[7:1]} : {state.rx[6:0], miso_sync};
				next_state.bits = state.bits + 4'h1;
				if (state.bits == 4'(char_bits - 1)) begin
					next_state.busy = 1'b0;
					next_state.done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '{busy: 1'b0, done: 1'b0, phase: 1'b0, bits: 4'h0, tx: 8'hff, rx: 8'h00, sck: 1'b1};
		end else begin
			state <= next_state;
		end
	end

	assign busy = state.busy;
	assign done = state.done;
	assign rx_byte = state.rx;
	assign sck = state.sck;
	assign mosi = lsb_first ? state.tx[0] : state.tx[7];
endmodule // sync_serial_shifter

// ===== sync_serial_master_burst.sv
// synchronous serial master channel with apb registers and event interrupt
// How it works
// - writing the data register starts one character; receive-only writes a dummy
// - event fires on buffer empty or on transfer end, as selected
// - status shows a transfer-in-progress flag the host can poll
// - bit 2 of peripheral clock enable gates the serial unit clock
// - mode code 00 synchronous, 01 asynchronous, 11 prohibited
// - interrupt source bit: 0 transfer end, 1 buffer empty
//
// The APB register port and the register offsets were chosen for this implementation.
module sync_serial_master_burst
	import sync_serial_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	output logic sck_out,
	output logic mosi_out,
	input wire logic miso_in,
	// interrupts
	output logic channel_irq,
	output logic irq_level
);
	typedef struct packed {
		logic [7:0] peripheral_clock_enable;
		logic [7:0] ctrl;
		logic [7:0] divider;
		logic [7:0] buffer;
		logic buffer_full;
		logic [7:0] shift_data_reg;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic channel_irq;
		logic irq_level;
		logic sck;
		logic mosi;
		logic [1:0] miso_sync;
	} top_state_t;
	top_state_t state, next_state;

	logic tick, busy, done, start;
	logic [7:0] rx_byte;
	logic sck_raw, mosi_raw;
	logic unit_clock_on, tx_en, rx_en, channel_on, src_empty, mode_ok;
	logic apb_access, wr, rd, buffer_empty_evt, event_pulse;

	assign unit_clock_on = state.peripheral_clock_enable[clk_gate_bit];
	assign tx_en = state.ctrl[ctrl_tx_en_bit];
	assign rx_en = state.ctrl[ctrl_rx_en_bit];
	// only synchronous mode runs the shifter
	assign mode_ok = state.ctrl[ctrl_mode_lo +: 2] == mode_csi;
	assign channel_on = unit_clock_on && mode_ok && (tx_en || rx_en);
	assign src_empty = state.ctrl[ctrl_src_bit];
	// buffered byte launches when the shifter is free
	assign start = channel_on && state.buffer_full && !busy;
	assign buffer_empty_evt = start;
	assign event_pulse = src_empty ? buffer_empty_evt : done;
	// apb access phase qualifiers; the answer flop blocks a second take
	assign apb_access = psel && penable && !state.pready;
	assign wr = apb_access && pwrite;
	assign rd = apb_access && !pwrite;

	sync_serial_tick u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(busy && unit_clock_on),
		.half_period(state.divider),
		.tick(tick)
	);

	sync_serial_shifter u_shifter (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick && unit_clock_on),
		.start(start),
		.tx_byte(tx_en ? state.buffer : 8'hff),
		.lsb_first(state.ctrl[ctrl_dir_bit]),
		.miso_sync(state.miso_sync[1]),
		.busy(busy),
		.done(done),
		.rx_byte(rx_byte),
		.sck(sck_raw),
		.mosi(mosi_raw)
	);

	// registers, bus answers and event flags
	always_comb begin
		next_state = state;
		next_state.miso_sync = {state.miso_sync[0], miso_in};
		next_state.pready = apb_access;
		next_state.pslverr = 1'b0;
		next_state.prdata = 32'h0000_0000;
		next_state.sck = sck_raw;
		next_state.mosi = mosi_raw;
		next_state.channel_irq = event_pulse;
		if (start) begin
			next_state.buffer_full = 1'b0;
		end
		if (done && rx_en) begin
			next_state.shift_data_reg = rx_byte;
		end
		// write decode; status registers ignore writes without error
		if (wr) begin
			if (paddr == off_data) begin
				next_state.buffer = pwdata[7:0];
				next_state.buffer_full = 1'b1;
			end else if (paddr == off_ctrl) begin
				// a channel restart reverts to transfer-end events
				next_state.ctrl = pwdata[7:0];
				if ((pwdata[ctrl_tx_en_bit] != tx_en) || (pwdata[ctrl_rx_en_bit] != rx_en)) begin
					next_state.ctrl[ctrl_src_bit] = 1'b0;
				end
			end else if (paddr == off_irq_mask) begin
				next_state.irq_mask = pwdata[1:0];
			end else if (paddr == off_clk_enable) begin
				next_state.peripheral_clock_enable = pwdata[7:0];
			end else if (paddr == off_divider) begin
				next_state.divider = pwdata[7:0];
			end else if (paddr != off_status && paddr != off_irq_status) begin
				next_state.pslverr = 1'b1;
			end
		end else if (rd) begin
			// read decode; data lines stay zero outside an answer
			if (paddr == off_data) begin
				next_state.prdata = {24'h000000, state.shift_data_reg};
			end else if (paddr == off_ctrl) begin
				next_state.prdata = {24'h000000, state.ctrl};
			end else if (paddr == off_status) begin
				next_state.prdata = {30'h0, state.buffer_full, busy};
			end else if (paddr == off_irq_status) begin
				next_state.prdata = {30'h0, state.irq_status};
				next_state.irq_status = 2'h0;
			end else if (paddr == off_irq_mask) begin
				next_state.prdata = {30'h0, state.irq_mask};
			end else if (paddr == off_clk_enable) begin
				next_state.prdata = {24'h000000, state.peripheral_clock_enable};
			end else if (paddr == off_divider) begin
				next_state.prdata = {24'h000000, state.divider};
			end else begin
				next_state.pslverr = 1'b1;
			end
		end
		// set wins over the read clear
		if (event_pulse) begin
			next_state.irq_status[irq_event_bit] = 1'b1;
		end
		if (state.ctrl[ctrl_mode_lo +: 2] == mode_bad) begin
			next_state.irq_status[irq_mode_err_bit] = 1'b1;
		end
		next_state.irq_level = |(next_state.irq_status & state.irq_mask);
	end

	// one register stage for the whole state; reset values are constants
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
			state.ctrl <= ctrl_reset;
			state.divider <= div_reset;
			state.peripheral_clock_enable <= pce_reset;
			state.sck <= 1'b1;
			state.mosi <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// pins and bus answers come straight from the state flops
	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign sck_out = state.sck;
	assign mosi_out = state.mosi;
	assign channel_irq = state.channel_irq;
	assign irq_level = state.irq_level;

	irq_one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn) channel_irq |=> !channel_irq)
		else $error("event pulse longer than one cycle");
	end_source_a: assert property (@(posedge pclk) disable iff (!presetn) (done && !src_empty) |=> channel_irq)
		else $error("transfer end event missed");
	empty_source_a: assert property (@(posedge pclk) disable iff (!presetn) (start && src_empty) |=> channel_irq)
		else $error("buffer empty event missed");
	clock_gate_a: assert property (@(posedge pclk) disable iff (!presetn) !unit_clock_on |-> !start)
		else $error("launch with unit clock stopped");
	write_starts_a: assert property (@(posedge pclk) disable iff (!presetn) (channel_on && state.buffer_full && !busy) |=> busy)
		else $error("write did not start transfer");
	busy_hold_a: assert property (@(posedge pclk) disable iff (!presetn) $rose(busy) |=> busy [*2])
		else $error("busy dropped early");
	mode_gate_a: assert property (@(posedge pclk) disable iff (!presetn) !mode_ok |-> !start)
		else $error("launch in non synchronous mode");
	mode_change_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == off_ctrl && pwdata[ctrl_tx_en_bit] != tx_en) |=> !src_empty)
		else $error("source not reverted");
	// apb answer is a one-cycle pulse
	bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn) apb_access |=> pready ##1 !pready)
		else $error("apb answer timing");

	// every pulse leaves its sticky flag
	irq_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		channel_irq |-> state.irq_status[irq_event_bit])
		else $error("event pulse not recorded");
	// level uses the mask that stood when it was computed
	level_track_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_level == |(state.irq_status & $past(state.irq_mask)))
		else $error("interrupt level out of step");
	// error flag only rides on an answer
	err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error without answer");
	// read data lines quiet between answers
	rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer");
	// an answer only follows a taken access
	answer_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> $past(apb_access))
		else $error("answer without access");
	// serial clock parks high between characters
	sck_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!busy |-> sck_raw)
		else $error("serial clock not idle high");
	// data line parks high once the character is out
	mosi_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!busy && !start) |=> mosi_raw)
		else $error("data line not idle high");
	// received byte lands in the data register
	rx_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done && rx_en) |=> state.shift_data_reg == $past(rx_byte))
		else $error("received byte not stored");
	// transmit-only keeps the last received byte
	rx_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done && !rx_en) |=> $stable(state.shift_data_reg))
		else $error("data register changed without receive");
	// launch empties the buffer unless rewritten
	buffer_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
		(start && !(wr && paddr == off_data)) |=> !state.buffer_full)
		else $error("buffer not drained by launch");
	// stopped unit clock freezes the link clock
	gate_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!unit_clock_on |=> $stable(sck_raw))
		else $error("link clock moved with unit clock stopped");
	// transfer-end source stays quiet on a launch
	end_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		(start && !src_empty && !done) |=> !channel_irq)
		else $error("launch event in transfer end mode");
	// status read shows the in-progress flag
	status_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == off_status) |=> prdata[0] == $past(busy))
		else $error("in progress flag misread");
	// control reads back what is held
	ctrl_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == off_ctrl) |=> prdata == {24'h000000, $past(state.ctrl)})
		else $error("control readback wrong");
	// prohibited code raises the error flag
	mode_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state.ctrl[ctrl_mode_lo +: 2] == mode_bad) |=> state.irq_status[irq_mode_err_bit])
		else $error("prohibited mode not flagged");
	// status read clears the event flag when no new event
	read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == off_irq_status && !event_pulse) |=> !state.irq_status[irq_event_bit])
		else $error("event flag not cleared by read");

	// main scenarios reached
	cover_launch_c: cover property (@(posedge pclk) disable iff (!presetn) start);
	cover_done_c: cover property (@(posedge pclk) disable iff (!presetn) done && rx_en);
	cover_empty_c: cover property (@(posedge pclk) disable iff (!presetn) start && src_empty);
	cover_mode_err_c: cover property (@(posedge pclk) disable iff (!presetn) state.irq_status[irq_mode_err_bit]);
	cover_gate_c: cover property (@(posedge pclk) disable iff (!presetn) !unit_clock_on && state.buffer_full);
endmodule // sync_serial_master_burst

// ===== serial_slave_model.sv
// behavioural serial slave facing the channel's link pins
module serial_slave_model (
	// link pins
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// bench side
	input wire logic lsb_first,
	input wire logic [7:0] reply,
	output logic [7:0] got,
	output int nbytes
);
	timeunit 1ns;
	timeprecision 100ps;
	int n;
	logic armed;
	logic [7:0] sh;
	// idle: nothing captured yet
	initial begin
		n = 0;
		armed = 1'b0;
		nbytes = 0;
		miso = 1'b1;
		got = 8'h00;
		sh = 8'h00;
	end
	// next reply bit goes out on the falling clock edge
	always @(negedge sck) begin
		armed = 1'b1;
		miso <= lsb_first ? reply[n[2:0]] : reply[3'd7 - n[2:0]];
	end
	// capture on the rise; the unknown-to-high step at reset is no clock edge
	always @(posedge sck) begin
		if (armed) begin
			sh = lsb_first ? {mosi, sh[7:1]} : {sh[6:0], mosi};
			n = n + 1;
			if (n == 8) begin
				n = 0;
				got <= sh;
				nbytes <= nbytes + 1;
				miso <= ~miso;
			end
		end
	end
endmodule // serial_slave_model

// ===== test_sync_serial_master_burst.sv
// self-checking bench for the synchronous serial master channel
module test_sync_serial_master_burst;
	import sync_serial_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sck_out, mosi_out, miso_in;
	logic [7:0] paddr = 8'h00, reply = 8'h00, got, tx, rx_exp;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic channel_irq, irq_level, lsb = 0, e;
	int n_errors = 0, tests_run = 0, cycles = 0, nb, nbytes, m;
	sync_serial_master_burst dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_out(sck_out),
		.mosi_out(mosi_out), .miso_in(miso_in), .channel_irq(channel_irq), .irq_level(irq_level));
	serial_slave_model slave (.sck(sck_out), .mosi(mosi_out), .miso(miso_in), .lsb_first(lsb), .reply(reply),
		.got(got), .nbytes(nbytes));
	always #2.5 pclk = ~pclk;
	// hang guard: a run this long means a lost handshake
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string what);
		tests_run++;
		if (g !== x) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, g, x);
		end
	endtask
	// one apb transfer: held from setup until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk iff pready);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string what);
		apb(1'b0, a, 32'h0);
		chk(r, x, what);
	endtask
	// expected byte on the wire: receive-only launches with a dummy of all ones
	function automatic logic [7:0] sent(input int md, input logic [7:0] d);
		return (md == 1) ? 8'hff : d;
	endfunction
	// send a byte and confirm shifting began
	task automatic launch(input logic [7:0] d);
		apb(1'b1, off_data, {24'h0, d});
		do apb(1'b0, off_status, 32'h0); while (r[0] !== 1'b1 && cycles < 50000);
	endtask
	initial begin
		void'($urandom(32'h3907));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(off_ctrl, {24'h0, ctrl_reset}, "ctrl reset");
		rd(off_clk_enable, {24'h0, pce_reset}, "clock enable reset");
		rd(off_divider, {24'h0, div_reset}, "divider reset");
		rd(off_status, 32'h0, "status reset");
		apb(1'b1, 8'h1c, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped error");
		apb(1'b1, off_clk_enable, 32'h4);
		rd(off_clk_enable, 32'h4, "gate bit");
		apb(1'b1, off_divider, 32'h5);
		apb(1'b1, off_irq_mask, 32'h3);
		// single characters in every direction and bit order, transfer-end events
		for (int i = 0; i < 9; i++) begin
			m = (i % 3) + 1;
			lsb <= i[0];
			tx = $urandom();
			reply <= $urandom();
			apb(1'b1, off_ctrl, {26'h0, i[0], 3'h0, m[1:0]});
			launch(tx);
			@(posedge pclk iff channel_irq);
			chk({24'h0, got}, {24'h0, sent(m, tx)}, "byte on wire");
			rx_exp = reply;
			apb(1'b0, off_data, 32'h0);
			if (m != 2) chk(r, {24'h0, rx_exp}, "received byte");
			chk({31'h0, irq_level}, 32'h1, "event level");
			rd(off_irq_status, 32'h1, "event status");
			rd(off_irq_status, 32'h0, "status cleared");
		end
		// burst of three: buffer-empty events, last one on transfer end
		lsb <= 1'b0;
		apb(1'b1, off_ctrl, 32'h3);
		apb(1'b1, off_ctrl, 32'h7);
		rd(off_ctrl, 32'h7, "source kept");
		nb = nbytes;
		launch(8'ha5);
		apb(1'b1, off_data, 32'h3c);
		@(posedge pclk iff channel_irq);
		chk({24'h0, got}, 32'ha5, "burst first");
		rd(off_data, {24'h0, reply}, "burst rx first");
		apb(1'b1, off_data, 32'hc3);
		@(posedge pclk iff channel_irq);
		chk({24'h0, got}, 32'h3c, "burst second");
		rd(off_data, {24'h0, reply}, "burst rx second");
		apb(1'b1, off_ctrl, 32'h3);
		@(posedge pclk iff channel_irq);
		chk({24'h0, got}, 32'hc3, "burst last");
		rd(off_data, {24'h0, reply}, "burst rx last");
		chk(nbytes - nb, 3, "burst count");
		// receive burst of two: dummy relaunch on each transfer end
		apb(1'b1, off_ctrl, 32'h1);
		for (int k = 0; k < 2; k++) begin
			reply <= $urandom();
			launch(8'hff);
			@(posedge pclk iff channel_irq);
			rd(off_data, {24'h0, reply}, "receive burst byte");
		end
		// stopped unit clock holds a queued byte until the clock returns
		apb(1'b1, off_ctrl, 32'h3);
		apb(1'b1, off_clk_enable, 32'h0);
		nb = nbytes;
		apb(1'b1, off_data, 32'h5a);
		repeat (40) @(posedge pclk);
		rd(off_status, 32'h2, "gated idle");
		chk(nbytes - nb, 0, "gated nothing sent");
		apb(1'b1, off_clk_enable, 32'h4);
		@(posedge pclk iff channel_irq);
		chk({24'h0, got}, 32'h5a, "released byte");
		// zero-count request: nothing is written, so nothing moves
		nb = nbytes;
		repeat (200) @(posedge pclk);
		rd(off_status, 32'h0, "zero count idle");
		chk(nbytes - nb, 0, "zero count nothing sent");
		// enable change forces transfer-end timing
		apb(1'b1, off_ctrl, 32'h7);
		apb(1'b1, off_ctrl, 32'h5);
		rd(off_ctrl, 32'h1, "source reverts");
		// prohibited mode code raises the error flag, masked then unmasked
		apb(1'b0, off_irq_status, 32'h0);
		apb(1'b1, off_irq_mask, 32'h1);
		apb(1'b1, off_ctrl, 32'h1b);
		chk({31'h0, irq_level}, 32'h0, "masked error");
		apb(1'b1, off_irq_mask, 32'h2);
		chk({31'h0, irq_level}, 32'h1, "error level");
		// back to a legal code first, else the flag sets again at once
		apb(1'b1, off_ctrl, 32'h3);
		rd(off_irq_status, 32'h2, "error status");
		chk({31'h0, irq_level}, 32'h0, "level cleared");
		conclude();
	end
endmodule // test_sync_serial_master_burst
